// *** vspc_pkg.sv ***
// Register map, field positions, reset values and timing constants for sync processing
package vspc_pkg;
  // Register offsets on the two-wire port
  localparam logic [7:0] ADDR_SEP_THRESH  = 8'h11;
  localparam logic [7:0] ADDR_HCTL        = 8'h12;
  localparam logic [7:0] ADDR_HWIDTH      = 8'h13;
  localparam logic [7:0] ADDR_VCTL        = 8'h14;
  localparam logic [7:0] ADDR_VWIDTH      = 8'h15;
  localparam logic [7:0] ADDR_PRE_COAST   = 8'h16;
  localparam logic [7:0] ADDR_POST_COAST  = 8'h17;
  localparam logic [7:0] ADDR_COAST_CTL   = 8'h18;
  // Reset values
  localparam logic [7:0] RST_SEP_THRESH   = 8'h20;
  localparam logic [7:0] RST_HCTL         = 8'h18;
  localparam logic [7:0] RST_HWIDTH       = 8'h20;
  localparam logic [7:0] RST_VCTL         = 8'h18;
  localparam logic [7:0] RST_VWIDTH       = 8'h0a;
  localparam logic [7:0] RST_PRE_COAST    = 8'h00;
  localparam logic [7:0] RST_POST_COAST   = 8'h00;
  localparam logic [7:0] RST_COAST_CTL    = 8'h20;
  // Field positions; bits 7 to 3 are shared by horizontal and vertical control
  localparam int SRC_OVR  = 7;
  localparam int SRC_SEL  = 6;
  localparam int POL_OVR  = 5;
  localparam int POL_IN   = 4;
  localparam int POL_OUT  = 3;
  localparam int V_FILTER = 2;
  localparam int V_WIDTH  = 1;
  localparam int COAST_EXT = 7;
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int H_ACT_NS      = 100000;
  localparam int V_ACT_NS      = 20000000;
  localparam int SEP_WIDE_NS   = 10000;
  localparam int H_ACT_CYCLES  = H_ACT_NS / CLK_PERIOD_NS;
  localparam int V_ACT_CYCLES  = V_ACT_NS / CLK_PERIOD_NS;
  localparam int SEP_WIDE_CYCLES = (SEP_WIDE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : vspc_pkg

// *** vspc_serial.sv ***
// Two-wire serial register port slave with auto-incrementing register pointer
`timescale 1ns/100ps
`default_nettype none
module vspc_serial #(
  parameter logic [6:0] DEV_ADDR = 7'h4c  // Arbitrary value
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  output var  logic [7:0] reg_addr,
  input  wire logic [7:0] reg_rdata,
  output var  logic       wr_en,
  output var  logic [7:0] wr_addr,
  output var  logic [7:0] wr_data
);
  typedef enum logic [2:0] {
    SP_IDLE = 3'b000, SP_ADDR = 3'b001, SP_ACKA = 3'b011, SP_WR = 3'b010,
    SP_ACKW = 3'b110, SP_RD = 3'b111, SP_ACKR = 3'b101
  } vspc_sp_t;
  typedef struct packed {
    vspc_sp_t   state;
    logic       scl_d, sda_d, rw, first;
    logic [3:0] bitc;
    logic [7:0] sh, ptr, waddr, wdata;
    logic       wr, oe;
  } vspc_ser_t;
  vspc_ser_t st, next_st;
  logic rise, fall;

  always_comb begin
    next_st = st;
    next_st.scl_d = scl_in;
    next_st.sda_d = sda_in;
    next_st.wr = 1'b0;
    rise = scl_in & ~st.scl_d;
    fall = ~scl_in & st.scl_d;
    if (scl_in && st.scl_d && st.sda_d && !sda_in) begin
      next_st.state = SP_ADDR;
      next_st.bitc = 4'h0;
      next_st.oe = 1'b0;
    end else if (scl_in && st.scl_d && !st.sda_d && sda_in) begin
      next_st.state = SP_IDLE;
      next_st.oe = 1'b0;
    end else if (rise) begin
      case (st.state)
        SP_ADDR, SP_WR: begin
          next_st.sh = {st.sh[6:0], sda_in};
          next_st.bitc = st.bitc + 4'h1;
        end
        SP_ACKR: if (sda_in) next_st.state = SP_IDLE;  // Master refused more data
        default: ;
      endcase
    end else if (fall) begin
      case (st.state)
        SP_ADDR: if (st.bitc == 4'h8) begin
          next_st.bitc = 4'h0;
          if (st.sh[7:1] == DEV_ADDR) begin
            next_st.rw = st.sh[0];
            next_st.oe = 1'b1;
            next_st.state = SP_ACKA;
          end else begin
            next_st.state = SP_IDLE;
          end
        end
        SP_ACKA, SP_ACKR: begin
          if (st.rw) begin
            next_st.sh = reg_rdata;
            next_st.oe = ~reg_rdata[7];
            next_st.bitc = 4'h1;
            next_st.state = SP_RD;
          end else begin
            next_st.oe = 1'b0;
            next_st.first = 1'b1;
            next_st.state = SP_WR;
          end
        end
        SP_WR: if (st.bitc == 4'h8) begin
          next_st.bitc = 4'h0;
          next_st.oe = 1'b1;
          next_st.state = SP_ACKW;
          next_st.first = 1'b0;
          if (st.first) begin
            next_st.ptr = st.sh;
          end else begin
            next_st.wr = 1'b1;
            next_st.waddr = st.ptr;
            next_st.wdata = st.sh;
            next_st.ptr = st.ptr + 8'h01;
          end
        end
        SP_ACKW: begin
          next_st.oe = 1'b0;
          next_st.state = SP_WR;
        end
        SP_RD: begin
          if (st.bitc == 4'h8) begin
            next_st.oe = 1'b0;
            next_st.ptr = st.ptr + 8'h01;
            next_st.state = SP_ACKR;
          end else begin
            next_st.oe = ~st.sh[3'(4'h7 - st.bitc)];
            next_st.bitc = st.bitc + 4'h1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st <= '0;
      st.scl_d <= 1'b1;
      st.sda_d <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Open drain: the pin is only ever pulled low
  assign sda_out  = 1'b0;
  assign sda_oe   = st.oe;
  assign reg_addr = st.ptr;
  assign wr_en    = st.wr;
  assign wr_addr  = st.waddr;
  assign wr_data  = st.wdata;
endmodule : vspc_serial
`default_nettype wire

// *** vspc_top.sv ***
// Sync source selection, polarity handling, sync regeneration and coast generation
`timescale 1ns/100ps
`default_nettype none
module vspc_top #(
  parameter logic [6:0]  DEV_ADDR    = 7'h4c,  // Arbitrary value
  parameter logic [19:0] H_ACT_LIMIT = 20'(vspc_pkg::H_ACT_CYCLES),
  parameter logic [19:0] V_ACT_LIMIT = 20'(vspc_pkg::V_ACT_CYCLES)
) (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output var  logic        sda_out,
  output var  logic        sda_oe,
  input  wire logic        horizontal_input_a,
  input  wire logic        horizontal_input_b,
  input  wire logic        vertical_input_a,
  input  wire logic        vertical_input_b,
  input  wire logic        input_channel_sel,
  input  wire logic        sync_on_green_input,
  input  wire logic [7:0]  composite_level,
  input  wire logic        external_coast,
  output var  logic        hsync_out,
  output var  logic        vsync_out,
  output var  logic        coast_out,
  output var  logic [11:0] lines_per_vsync
);
  typedef struct packed {
    logic [7:0]        thresh, hctl, hwid, vctl, vwid, pre, post, cctl;
    logic [2:0]        src_d;
    logic [2:0][19:0]  act;
    logic [1:0][11:0]  acc;
    logic [11:0]       seprun;
    logic              sep_vs, h_d, vfilt, v_d, hout, vout, cout;
    logic [7:0]        hcnt, vcnt;
    logic [11:0]       lines, frame_len;
  } vspc_state_t;
  vspc_state_t st, next_st;

  logic [7:0]  reg_addr, reg_rdata, wr_addr, wr_data;
  logic        wr_en;
  logic        h_pin, v_pin, h_use_sog, v_use_sep, h_raw, v_raw;
  logic        act_h, act_sog, act_v, h_hi, v_hi, h_n, v_n, h_lead;
  logic        v_sig, v_lead, sep_cmp, coast_int;
  logic [2:0]  src;
  logic [12:0] pre_sum;

  vspc_serial #(.DEV_ADDR(DEV_ADDR)) u_serial (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .sda_out   (sda_out),
    .sda_oe    (sda_oe),
    .reg_addr  (reg_addr),
    .reg_rdata (reg_rdata),
    .wr_en     (wr_en),
    .wr_addr   (wr_addr),
    .wr_data   (wr_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    case (reg_addr)
      vspc_pkg::ADDR_SEP_THRESH: reg_rdata = st.thresh;
      vspc_pkg::ADDR_HCTL:       reg_rdata = st.hctl;
      vspc_pkg::ADDR_HWIDTH:     reg_rdata = st.hwid;
      vspc_pkg::ADDR_VCTL:       reg_rdata = st.vctl;
      vspc_pkg::ADDR_VWIDTH:     reg_rdata = st.vwid;
      vspc_pkg::ADDR_PRE_COAST:  reg_rdata = st.pre;
      vspc_pkg::ADDR_POST_COAST: reg_rdata = st.post;
      vspc_pkg::ADDR_COAST_CTL:  reg_rdata = st.cctl;
      default:                   reg_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_st = st;
    if (wr_en) begin
      case (wr_addr)
        vspc_pkg::ADDR_SEP_THRESH: next_st.thresh = wr_data;
        vspc_pkg::ADDR_HCTL:       next_st.hctl = wr_data;
        vspc_pkg::ADDR_HWIDTH:     next_st.hwid = wr_data;
        vspc_pkg::ADDR_VCTL:       next_st.vctl = wr_data;
        vspc_pkg::ADDR_VWIDTH:     next_st.vwid = wr_data;
        vspc_pkg::ADDR_PRE_COAST:  next_st.pre = wr_data;
        vspc_pkg::ADDR_POST_COAST: next_st.post = wr_data;
        vspc_pkg::ADDR_COAST_CTL:  next_st.cctl = wr_data;
        default: ;
      endcase
    end
    h_pin = input_channel_sel ? horizontal_input_b : horizontal_input_a;
    v_pin = input_channel_sel ? vertical_input_b : vertical_input_a;
    // Activity: a source is live if it toggled within its timeout
    src = {v_pin, sync_on_green_input, h_pin};
    next_st.src_d = src;
    for (int i = 0; i < 3; i++) begin
      if (src[i] != st.src_d[i]) begin
        next_st.act[i] = 20'h0_0000;
      end else if (st.act[i] != ((i == 2) ? V_ACT_LIMIT : H_ACT_LIMIT)) begin
        next_st.act[i] = st.act[i] + 20'h0_0001;
      end
    end
    act_h   = st.act[0] != H_ACT_LIMIT;
    act_sog = st.act[1] != H_ACT_LIMIT;
    act_v   = st.act[2] != V_ACT_LIMIT;
    if (st.hctl[vspc_pkg::SRC_OVR] || (act_h && act_sog)) begin
      h_use_sog = st.hctl[vspc_pkg::SRC_SEL];
    end else begin
      h_use_sog = !act_h && act_sog;
    end
    h_raw = h_use_sog ? sync_on_green_input : h_pin;
    // Separator: a long stay below threshold marks vertical sync
    sep_cmp = composite_level < st.thresh;
    next_st.seprun = sep_cmp ? ((st.seprun == 12'hfff) ? st.seprun : st.seprun + 12'h001) : 12'h000;
    next_st.sep_vs = st.seprun >= 12'(vspc_pkg::SEP_WIDE_CYCLES);
    v_use_sep = st.vctl[vspc_pkg::SRC_OVR] ? st.vctl[vspc_pkg::SRC_SEL] : !act_v;
    v_raw = v_use_sep ? st.sep_vs : v_pin;
    // Polarity: the level held for less time is the active one
    for (int i = 0; i < 2; i++) begin
      if ((i == 0) ? h_raw : v_raw) begin
        if (st.acc[i] != 12'h7ff) next_st.acc[i] = st.acc[i] + 12'h001;
      end else if (st.acc[i] != 12'h800) begin
        next_st.acc[i] = st.acc[i] - 12'h001;
      end
    end
    h_hi = st.hctl[vspc_pkg::POL_OVR] ? st.hctl[vspc_pkg::POL_IN] : st.acc[0][11];
    v_hi = st.vctl[vspc_pkg::POL_OVR] ? st.vctl[vspc_pkg::POL_IN] : st.acc[1][11];
    h_n = h_raw ~^ h_hi;
    v_n = v_raw ~^ v_hi;
    // Horizontal regeneration
    next_st.h_d = h_n;
    h_lead = h_n & ~st.h_d;
    if (h_lead) begin
      next_st.hcnt = st.hwid;
    end else if (st.hcnt != 8'h00) begin
      next_st.hcnt = st.hcnt - 8'h01;
    end
    next_st.hout = (next_st.hcnt != 8'h00) ~^ st.hctl[vspc_pkg::POL_OUT];
    // Filter samples vertical only at line starts, rejecting mid-line glitches
    if (h_lead) next_st.vfilt = v_n;
    v_sig = st.vctl[vspc_pkg::V_FILTER] ? st.vfilt : v_n;
    next_st.v_d = v_sig;
    v_lead = v_sig & ~st.v_d;
    if (v_lead) begin
      next_st.vcnt = st.vwid;
    end else if (h_lead && st.vcnt != 8'h00) begin
      next_st.vcnt = st.vcnt - 8'h01;
    end
    if (st.vctl[vspc_pkg::V_WIDTH]) begin
      next_st.vout = (next_st.vcnt != 8'h00) ~^ st.vctl[vspc_pkg::POL_OUT];
    end else begin
      next_st.vout = v_sig ~^ st.vctl[vspc_pkg::POL_OUT];
    end
    // Line counting per frame; frame length is trusted only when filtered
    if (v_lead) begin
      next_st.lines = 12'h000;
      if (st.vctl[vspc_pkg::V_FILTER]) next_st.frame_len = st.lines;
    end else if (h_lead && st.lines != 12'hfff) begin
      next_st.lines = st.lines + 12'h001;
    end
    // Pre-coast predicts the next vertical from the last frame length
    pre_sum = {1'b0, st.lines} + {5'h00, st.pre};
    coast_int = (st.frame_len != 12'h000 && st.pre != 8'h00 && pre_sum >= {1'b0, st.frame_len})
              || (st.lines < {4'h0, st.post});
    next_st.cout = st.cctl[vspc_pkg::COAST_EXT] ? external_coast : coast_int;
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      st <= '0;
      st.thresh <= vspc_pkg::RST_SEP_THRESH;
      st.hctl <= vspc_pkg::RST_HCTL;
      st.hwid <= vspc_pkg::RST_HWIDTH;
      st.vctl <= vspc_pkg::RST_VCTL;
      st.vwid <= vspc_pkg::RST_VWIDTH;
      st.pre <= vspc_pkg::RST_PRE_COAST;
      st.post <= vspc_pkg::RST_POST_COAST;
      st.cctl <= vspc_pkg::RST_COAST_CTL;
      st.act <= {V_ACT_LIMIT, H_ACT_LIMIT, H_ACT_LIMIT};
      st.lines <= 12'hfff;
    end else begin
      st <= next_st;
    end
  end

  assign hsync_out = st.hout;
  assign vsync_out = st.vout;
  assign coast_out = st.cout;
  assign lines_per_vsync = st.frame_len;

  ////////////////////////////////////////////////////////////////////////////
  AST_HSRC_OVR: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.hctl[7] |-> (h_raw == (st.hctl[6] ? sync_on_green_input : h_pin)))
    else $error("horizontal source override ignored");
  AST_HSRC_BOTH: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!st.hctl[7] && act_h && act_sog) |-> (h_use_sog == st.hctl[6]))
    else $error("horizontal select ignored with both sources live");
  AST_HPOL: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.hctl[5] |-> (h_n == (st.hctl[4] ? h_raw : !h_raw)))
    else $error("horizontal polarity override ignored");
  AST_HWIDTH: assert property (@(posedge ref_clk) disable iff (!rstn)
    (h_lead && !wr_en && st.hwid != 8'h00) |=>
      (st.hcnt == $past(st.hwid)) ##1 (st.hcnt == $past(st.hcnt) - 8'h01 || h_lead))
    else $error("horizontal pulse count wrong");
  AST_HOUT_POL: assert property (@(posedge ref_clk) disable iff (!rstn)
    (st.hcnt == 8'h00 && !h_lead) |=> (hsync_out == !$past(st.hctl[3])))
    else $error("idle horizontal output level wrong");
  AST_VSRC: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.vctl[7] |-> (v_raw == (st.vctl[6] ? st.sep_vs : v_pin)))
    else $error("vertical source override ignored");
  AST_VPASS: assert property (@(posedge ref_clk) disable iff (!rstn)
    !st.vctl[1] |=> (vsync_out == ($past(v_sig) ~^ $past(st.vctl[3]))))
    else $error("vertical output not passed through");
  AST_COAST_EXT: assert property (@(posedge ref_clk) disable iff (!rstn)
    st.cctl[7] |=> (coast_out == $past(external_coast)))
    else $error("external coast not used");
  AST_POSTCOAST: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!st.cctl[7] && st.lines < {4'h0, st.post}) |=> coast_out)
    else $error("post coast window missed");
endmodule : vspc_top
`default_nettype wire

// *** vspc_sync_model.sv ***
// Sync source feeding the block and downstream monitor of regenerated horizontal sync
`timescale 1ns/100ps
`default_nettype none
module vspc_sync_model (
  input  wire logic       ref_clk,
  input  wire logic       gen_en,
  input  wire logic [7:0] period,
  input  wire logic       out_pol,
  input  wire logic       hsync_out,
  output var  logic       h_gen,
  output var  logic [8:0] last_width,
  output var  logic [7:0] n_pulses
);
  logic [7:0] phase;
  logic [8:0] run;

  initial begin
    phase = 8'h00;
    run = 9'h000;
    h_gen = 1'b0;
    last_width = 9'h000;
    n_pulses = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active-high pulses of four clocks; idle low between lines like a real source
  always @(negedge ref_clk) begin
    if (!gen_en) begin
      phase <= 8'h00;
      h_gen <= 1'b0;
    end else begin
      phase <= (phase + 8'h01 >= period) ? 8'h00 : phase + 8'h01;
      h_gen <= (phase < 8'h04);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Run length of each active output pulse, in ref_clk cycles
  always @(posedge ref_clk) begin
    if (hsync_out === out_pol) begin
      run <= run + 9'h001;
    end else begin
      if (run != 9'h000) begin
        last_width <= run;
        n_pulses <= n_pulses + 8'h01;
      end
      run <= 9'h000;
    end
  end
endmodule : vspc_sync_model
`default_nettype wire

// *** tb.sv ***
// Self-checking bench: register port, horizontal regeneration, vertical path, coast, separator
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        ref_clk, rstn, scl, sda_m, chan, ext_coast, gen_en, out_pol, v_drv;
  logic [1:0]  h_route;
  logic [7:0]  level;
  wire  logic  sda_out, sda_oe, h_gen, hsync_out, vsync_out, coast_out;
  wire  logic [8:0]  last_width;
  wire  logic [7:0]  n_pulses;
  wire  logic [11:0] lines;
  wire  logic  sda = sda_m & ~sda_oe;
  int          errors, n_compared;

  vspc_top #(.DEV_ADDR(7'h4c), .H_ACT_LIMIT(20'h0040), .V_ACT_LIMIT(20'h0200)) u_dut (
    .ref_clk(ref_clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .horizontal_input_a(h_gen & (h_route == 2'h1)), .horizontal_input_b(h_gen & (h_route == 2'h2)),
    .vertical_input_a(v_drv & ~chan), .vertical_input_b(v_drv & chan), .input_channel_sel(chan),
    .sync_on_green_input(h_gen & (h_route == 2'h3)), .composite_level(level),
    .external_coast(ext_coast), .hsync_out(hsync_out), .vsync_out(vsync_out),
    .coast_out(coast_out), .lines_per_vsync(lines));
  vspc_sync_model u_src (.ref_clk(ref_clk), .gen_en(gen_en), .period(8'h28), .out_pol(out_pol),
    .hsync_out(hsync_out), .h_gen(h_gen), .last_width(last_width), .n_pulses(n_pulses));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [11:0] seen, input logic [11:0] expd);
    n_compared++;
    if (seen !== expd) begin
      errors++;
      $display("Error %s expected %h seen %h", what, expd, seen);
    end
  endtask : check

  task automatic wait_clk(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : wait_clk

  // Four clocks per phase keeps the slave's pin sampling well inside each level
  task automatic i2c_bit(input logic b, output logic r);
    sda_m = b;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(4);
    r = sda;
    scl = 1'b0;
    wait_clk(1);
  endtask : i2c_bit

  task automatic i2c_start;
    sda_m = 1'b1;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(4);
    sda_m = 1'b0;
    wait_clk(4);
    scl = 1'b0;
    wait_clk(4);
  endtask : i2c_start

  task automatic i2c_stop;
    sda_m = 1'b0;
    wait_clk(4);
    scl = 1'b1;
    wait_clk(4);
    sda_m = 1'b1;
    wait_clk(4);
  endtask : i2c_stop

  task automatic i2c_byte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(d[i], q[i]);
    i2c_bit(ack_in, ack);
  endtask : i2c_byte

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic k0, k1, k2;
    i2c_start;
    i2c_byte(8'h98, 1'b1, q, k0);
    i2c_byte(a, 1'b1, q, k1);
    i2c_byte(d, 1'b1, q, k2);
    i2c_stop;
    check("write ack", {k0, k1, k2}, 12'h000);
  endtask : reg_write

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    i2c_start;
    i2c_byte(8'h98, 1'b1, q, k0);
    i2c_byte(a, 1'b1, q, k1);
    i2c_start;
    i2c_byte(8'h99, 1'b1, q, k2);
    i2c_byte(8'hff, 1'b1, d, k3);
    i2c_stop;
    check("read ack", {k0, k1, k2}, 12'h000);
  endtask : reg_read

  task automatic run_h(input logic [1:0] r, output logic [7:0] gained);
    logic [7:0] n0;
    n0 = n_pulses;
    h_route = r;
    gen_en = 1'b1;
    wait_clk(400);
    gen_en = 1'b0;
    wait_clk(60);
    gained = n_pulses - n0;
  endtask : run_h

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [7:0] rv [8] = '{8'h20, 8'h18, 8'h20, 8'h18, 8'h0a, 8'h00, 8'h00, 8'h20};
    logic [7:0] q;
    logic       a;
    for (int i = 0; i < 8; i++) begin
      reg_read(8'h11 + 8'(i), q);
      check("reset value", q, rv[i]);
    end
    reg_write(8'h16, 8'h5a);
    reg_read(8'h16, q);
    check("readback", q, 8'h5a);
    reg_write(8'h16, 8'h00);
    reg_write(8'h30, 8'h77);
    reg_read(8'h30, q);
    check("unmapped", q, 8'h00);
    i2c_start;
    i2c_byte(8'h9a, 1'b1, q, a);
    i2c_stop;
    check("foreign address ack", a, 1'b1);
  endtask : t_regs

  task automatic t_hsync;
    logic [7:0] w [3] = '{8'h01, 8'h03, 8'h20};
    logic [7:0] g;
    reg_write(8'h12, 8'hb8);
    for (int i = 0; i < 3; i++) begin
      reg_write(8'h13, w[i]);
      run_h(2'h1, g);
      check("hsync width", last_width, w[i]);
    end
    reg_write(8'h12, 8'hb0);
    out_pol = 1'b0;
    wait_clk(3);
    check("hsync idle", hsync_out, 1'b1);
    run_h(2'h1, g);
    check("hsync width low", last_width, 9'h020);
    out_pol = 1'b1;
    reg_write(8'h12, 8'hf8);
    run_h(2'h1, g);
    check("pin under sog select", g, 8'h00);
    run_h(2'h3, g);
    check("sog pulses", g != 8'h00, 1'b1);
    reg_write(8'h12, 8'hb8);
    chan = 1'b1;
    run_h(2'h1, g);
    check("unselected channel", g, 8'h00);
    run_h(2'h2, g);
    check("channel b pulses", g != 8'h00, 1'b1);
    chan = 1'b0;
    reg_write(8'h12, 8'h38);
    run_h(2'h3, g);
    check("auto source sog", g != 8'h00, 1'b1);
  endtask : t_hsync

  task automatic t_vsync;
    reg_write(8'h14, 8'hb8);
    v_drv = 1'b1;
    wait_clk(3);
    check("vsync active", vsync_out, 1'b1);
    v_drv = 1'b0;
    wait_clk(3);
    check("vsync idle", vsync_out, 1'b0);
    reg_write(8'h14, 8'hb0);
    wait_clk(3);
    check("vsync idle low", vsync_out, 1'b1);
    reg_write(8'h14, 8'ha8);
    wait_clk(3);
    check("active-low input", vsync_out, 1'b1);
  endtask : t_vsync

  // Filter and duration enabled together, as the controller is expected to do
  task automatic t_frames;
    int act, cst;
    act = 0;
    cst = 0;
    reg_write(8'h12, 8'hb8);
    reg_write(8'h15, 8'h02);
    reg_write(8'h17, 8'h03);
    reg_write(8'h14, 8'hbe);
    h_route = 2'h1;
    v_drv = 1'b0;
    gen_en = 1'b1;
    // Twelve idle lines flush the filter and a duration count left by earlier scenarios
    wait_clk(480);
    for (int i = 0; i < 1200; i++) begin
      v_drv = (i % 400) < 120;
      act += int'(vsync_out === 1'b1);
      cst += int'(coast_out === 1'b1);
      wait_clk(1);
    end
    gen_en = 1'b0;
    check("vsync duration", act >= 220 && act <= 260, 1'b1);
    check("lines per vsync", lines, 12'h00a);
    check("post coast", cst >= 320 && cst <= 400, 1'b1);
  endtask : t_frames

  task automatic t_coast_sep;
    reg_write(8'h18, 8'ha0);
    ext_coast = 1'b1;
    wait_clk(3);
    check("external coast", coast_out, 1'b1);
    ext_coast = 1'b0;
    wait_clk(3);
    check("external coast off", coast_out, 1'b0);
    reg_write(8'h14, 8'hf8);
    level = 8'h10;
    wait_clk(600);
    check("separator vsync", vsync_out, 1'b1);
    level = 8'h80;
    wait_clk(600);
    check("separator idle", vsync_out, 1'b0);
    reg_write(8'h11, 8'h08);
    level = 8'h10;
    wait_clk(600);
    check("above threshold", vsync_out, 1'b0);
    level = 8'h80;
  endtask : t_coast_sep

  task automatic test_done;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rstn = 1'b0;
    scl = 1'b1;
    sda_m = 1'b1;
    chan = 1'b0;
    ext_coast = 1'b0;
    gen_en = 1'b0;
    out_pol = 1'b1;
    v_drv = 1'b0;
    h_route = 2'h0;
    level = 8'h80;
    errors = 0;
    n_compared = 0;
    repeat (12) @(negedge ref_clk);
    rstn = 1'b1;
    wait_clk(2);
    t_regs;
    t_hsync;
    t_vsync;
    t_frames;
    t_coast_sep;
    test_done;
  end

  // Expected run is about 17k clocks; over twice that means something hung
  initial begin
    repeat (40000) @(posedge ref_clk);
    errors++;
    test_done;
  end
endmodule : tb
`default_nettype wire
